/* hw/dncm_pkg.sv */
package dncm_pkg;
    localparam int SAMPLE_W   = 12;
    localparam int OUT_W      = 15;
    localparam int LUT_W      = 14;
    localparam int PROD_W     = SAMPLE_W + LUT_W;
    localparam int ACC_W      = OUT_W + 2;
    localparam int NUM_OSC    = 4;
    localparam int DECIM      = 4;
    localparam int DECIM_LOG2 = 2;
    localparam int MIX_SHIFT  = 10;
    localparam int HOP_DELAY  = 45;
    localparam int RAT_LOG2   = 6;
    localparam int RAT_CNT_W  = 16 + RAT_LOG2;
    // register map
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_RDIV  = 8'h04;
    localparam logic [7:0] ADDR_STAT  = 8'h08;
    localparam logic [2:0] PAGE_FREQ  = 3'h1;
    localparam logic [2:0] PAGE_PHASE = 3'h2;
    // control fields and reset values
    localparam int CTRL_BYPASS = 0;
    localparam int CTRL_DUAL   = 1;
    localparam int CTRL_SRC    = 2;
    localparam int CTRL_BIND   = 3;
    localparam int CTRL_SEL_A  = 8;
    localparam int CTRL_SEL_B  = 10;
    localparam logic [31:0] CTRL_RST = 32'h0000_0002;
    localparam logic [15:0] RDIV_RST = 16'h0000;
    // saturation limits of the output code range
    localparam logic signed [39:0] SAT_MAX = 40'sh00_0000_3fff;
    localparam logic signed [39:0] SAT_MIN = -40'sh00_0000_4000;
    // quarter sine wave, 17 points
    localparam logic [12:0] SIN_Q [17] = '{
        13'h0000, 13'h0323, 13'h063e, 13'h094a, 13'h0c3f, 13'h0f15,
        13'h11c7, 13'h144d, 13'h16a0, 13'h18bc, 13'h1a9b, 13'h1c38,
        13'h1d90, 13'h1e9f, 13'h1f63, 13'h1fd9, 13'h1fff};

    // round to nearest, ties to even, then saturate
    function automatic logic signed [OUT_W-1:0] rnd_sat(
        input logic signed [39:0] v,
        input int                 sh
    );
        logic signed [39:0] q;
        logic [39:0]        rem;
        logic [39:0]        half;
        q    = v >>> sh;
        rem  = v & ((40'h1 << sh) - 40'h1);
        half = 40'h1 << (sh - 1);
        if (rem > half || (rem == half && q[0]))
            q = q + 40'sh1;
        if (q > SAT_MAX)
            q = SAT_MAX;
        else if (q < SAT_MIN)
            q = SAT_MIN;
        return q[OUT_W-1:0];
    endfunction : rnd_sat

    function automatic logic signed [LUT_W-1:0] sin_lut(
        input logic [5:0] ph
    );
        logic [4:0]              idx;
        logic signed [LUT_W-1:0] mag;
        idx = ph[4] ? 5'h10 - {1'b0, ph[3:0]} : {1'b0, ph[3:0]};
        mag = signed'({1'b0, SIN_Q[idx]});
        return ph[5] ? -mag : mag;
    endfunction : sin_lut

    function automatic logic [31:0] apply_strb(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  strb
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i])
                r[i*8 +: 8] = wd[i*8 +: 8];
        end
        return r;
    endfunction : apply_strb
endpackage : dncm_pkg

/* hw/dncm_nco.sv */
`timescale 1ns/10ps
`default_nettype none
module dncm_nco import dncm_pkg::*; (
    // clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    // oscillator settings
    input  wire logic [3:0][31:0]        freqWords,
    input  wire logic [3:0][15:0]        phaseOffsets,
    input  wire logic [15:0]             rdiv,
    input  wire logic [1:0]              oscSel,
    // carrier
    output logic signed [LUT_W-1:0]      cosOut,
    output logic signed [LUT_W-1:0]      sinOut
);
    logic [3:0][31:0]       acc_r;
    logic [RAT_CNT_W-1:0]   ratCnt_r;
    wire                    ratMode   = rdiv != 16'h0000;
    wire [RAT_CNT_W-1:0]    ratPeriod = {rdiv, 6'h00};
    wire                    ratWrap   = ratMode &&
                                (ratCnt_r >= ratPeriod - 22'h1);
    wire [31:0]             phase;

    assign phase = acc_r[oscSel] + {phaseOffsets[oscSel], 16'h0000};

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            acc_r    <= '0;
            ratCnt_r <= '0;
            cosOut   <= '0;
            sinOut   <= '0;
        end else begin
            ratCnt_r <= ratWrap || !ratMode ? '0 : ratCnt_r + 22'h1;
            for (int i = 0; i < NUM_OSC; i++) begin
                // all keep running; snap to exact period in rational mode
                acc_r[i] <= ratWrap ? 32'h0 :
                            acc_r[i] + freqWords[i];
            end
            cosOut <= sin_lut(phase[31:26] + 6'h10);
            sinOut <= sin_lut(phase[31:26]);
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    chk_acc_wrap:
        assert property (!ratMode && !$past(ratMode) |->
            acc_r[2] == $past(acc_r[2]) + $past(freqWords[2]))
        else $error("accumulator did not add its word");
    chk_rat_snap:
        assert property (ratWrap |=> acc_r[1] == 32'h0 && ratCnt_r == '0)
        else $error("rational period did not snap");
    cov_rat_wrap: cover property (ratWrap);
endmodule : dncm_nco
`default_nettype wire

/* hw/dncm_decim.sv */
`timescale 1ns/10ps
`default_nettype none
module dncm_decim import dncm_pkg::*; (
    // clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    // mixed input
    input  wire logic signed [OUT_W-1:0] inI,
    input  wire logic signed [OUT_W-1:0] inQ,
    input  wire logic                    inValid,
    // decimated output
    output logic signed [OUT_W-1:0]      outI,
    output logic signed [OUT_W-1:0]      outQ,
    output logic                         outValid
);
    logic [1:0]              tap_r;
    logic signed [ACC_W-1:0] accI_r;
    logic signed [ACC_W-1:0] accQ_r;
    wire signed [ACC_W-1:0]  sumI    = accI_r + ACC_W'(inI);
    wire signed [ACC_W-1:0]  sumQ    = accQ_r + ACC_W'(inQ);
    wire                     lastTap = tap_r == 2'(DECIM - 1);

    // averaging filter and decimation in one step, full precision sums
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tap_r    <= '0;
            accI_r   <= '0;
            accQ_r   <= '0;
            outI     <= '0;
            outQ     <= '0;
            outValid <= 1'b0;
        end else begin
            outValid <= inValid && lastTap;
            if (inValid) begin
                tap_r  <= tap_r + 2'h1;
                accI_r <= lastTap ? '0 : sumI;
                accQ_r <= lastTap ? '0 : sumQ;
            end
            if (inValid && lastTap) begin
                outI <= rnd_sat(40'(sumI), DECIM_LOG2);
                outQ <= rnd_sat(40'(sumQ), DECIM_LOG2);
            end
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    chk_decim_rate:
        assert property (outValid |=> !outValid [*3])
        else $error("decimated output faster than one in four");
    cov_decim_out: cover property (outValid);
endmodule : dncm_decim
`default_nettype wire

/* hw/dncm_top.sv */
// Implementation choices: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - sample goes to bypass or mixer path
// - mix to zero, then combined filter-decimate
// - dual mode: each input binds to A or B
// - single mode: second converter unavailable
// - convergent rounding, ties to even
// - every stage saturates, never wraps
// - filter sums full precision, round once
// - complex exponential from 32-bit word
// - output carrier at input plus oscillator
// - four accumulators, all always running
// - pin change hops oscillator, ~45-68 cycles
// - source bit picks pins or field
// - frequency and phase per accumulator
// - divider zero: word times clock over 2^32
// - word acts modulo 2^32, any signedness
// - new word leaves phase undefined; resync
// - nonzero divider gives exact frequency steps
// - 16-bit offset into upper half, added
module dncm_top import dncm_pkg::*; (
    // clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    // converter samples
    input  wire logic signed [SAMPLE_W-1:0] sampleA,
    input  wire logic signed [SAMPLE_W-1:0] sampleB,
    // hop pins
    input  wire logic [1:0]              hopPinsA,
    input  wire logic [1:0]              hopPinsB,
    // down converter A
    output logic signed [OUT_W-1:0]      outIA,
    output logic signed [OUT_W-1:0]      outQA,
    output logic                         outValidA,
    // down converter B
    output logic signed [OUT_W-1:0]      outIB,
    output logic signed [OUT_W-1:0]      outQB,
    output logic                         outValidB
);
    // configuration
    logic                    bypass_r;
    logic                    dualMode_r;
    logic                    oscSelectSource_r;
    logic [1:0]              inputBinding_r;
    logic [1:0][1:0]         oscSelectField_r;
    logic [15:0]             rationalStepDivider_r;
    logic [1:0][3:0][31:0]   freqWord_r;
    logic [1:0][3:0][15:0]   phaseOffset_r;
    logic [31:0]             prdata_r;
    // per converter state
    logic [1:0]              activeSel [2];
    logic signed [OUT_W-1:0] outI_r [2];
    logic signed [OUT_W-1:0] outQ_r [2];
    logic                    outValid_r [2];
    logic [31:0]             readMux;

    // address decode
    wire        apbWrite = psel && penable && pwrite;
    wire        rdSetup  = psel && !penable && !pwrite;
    wire        aligned  = paddr[1:0] == 2'h0;
    wire        hitCtrl  = paddr == ADDR_CTRL;
    wire        hitRdiv  = paddr == ADDR_RDIV;
    wire        hitStat  = paddr == ADDR_STAT;
    wire        hitFreq  = paddr[7:5] == PAGE_FREQ && aligned;
    wire        hitPhase = paddr[7:5] == PAGE_PHASE && aligned;
    wire        hit      = hitCtrl || hitRdiv || hitStat ||
                           hitFreq || hitPhase;
    wire        regDdc   = paddr[4];
    wire [1:0]  regOsc   = paddr[3:2];
    wire        ratMode  = rationalStepDivider_r != 16'h0000;

    // register images
    wire [31:0] ctrlImage = {20'h0, oscSelectField_r[1],
                             oscSelectField_r[0], 3'h0, inputBinding_r,
                             oscSelectSource_r, dualMode_r, bypass_r};
    wire [31:0] statImage = {27'h0, ratMode, activeSel[1], activeSel[0]};
    wire [31:0] ctrlNew   = apply_strb(ctrlImage, pwdata, pstrb);
    wire [31:0] rdivNew   = apply_strb({16'h0, rationalStepDivider_r},
                                       pwdata, pstrb);
    wire [31:0] freqNew   = apply_strb(freqWord_r[regDdc][regOsc],
                                       pwdata, pstrb);
    wire [31:0] phaseNew  = apply_strb({16'h0,
                                       phaseOffset_r[regDdc][regOsc]},
                                       pwdata, pstrb);

    assign readMux = hitCtrl  ? ctrlImage :
                     hitRdiv  ? {16'h0, rationalStepDivider_r} :
                     hitStat  ? statImage :
                     hitFreq  ? freqWord_r[regDdc][regOsc] :
                     hitPhase ? {16'h0, phaseOffset_r[regDdc][regOsc]} :
                     32'h0;

    // zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata  = prdata_r;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst)
            prdata_r <= 32'h0;
        else if (rdSetup)
            prdata_r <= readMux;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bypass_r              <= CTRL_RST[CTRL_BYPASS];
            dualMode_r            <= CTRL_RST[CTRL_DUAL];
            oscSelectSource_r     <= CTRL_RST[CTRL_SRC];
            inputBinding_r        <= CTRL_RST[CTRL_BIND +: 2];
            oscSelectField_r[0]   <= CTRL_RST[CTRL_SEL_A +: 2];
            oscSelectField_r[1]   <= CTRL_RST[CTRL_SEL_B +: 2];
            rationalStepDivider_r <= RDIV_RST;
            freqWord_r            <= '0;
            phaseOffset_r         <= '0;
        end else if (apbWrite) begin
            if (hitCtrl) begin
                bypass_r            <= ctrlNew[CTRL_BYPASS];
                dualMode_r          <= ctrlNew[CTRL_DUAL];
                oscSelectSource_r   <= ctrlNew[CTRL_SRC];
                inputBinding_r      <= ctrlNew[CTRL_BIND +: 2];
                oscSelectField_r[0] <= ctrlNew[CTRL_SEL_A +: 2];
                oscSelectField_r[1] <= ctrlNew[CTRL_SEL_B +: 2];
            end
            if (hitRdiv)
                rationalStepDivider_r <= rdivNew[15:0];
            // takes effect at once, phase is left where it is
            if (hitFreq)
                freqWord_r[regDdc][regOsc] <= freqNew;
            if (hitPhase)
                phaseOffset_r[regDdc][regOsc] <= phaseNew[15:0];
        end
    end

    // one down converter per channel
    for (genvar d = 0; d < 2; d++) begin : g_ddc
        logic [HOP_DELAY-1:0][1:0] hopPipe_r;
        logic signed [SAMPLE_W-1:0] smp_r;
        logic signed [OUT_W-1:0]    mixI_r;
        logic signed [OUT_W-1:0]    mixQ_r;
        logic                       mixValid_r;
        logic signed [LUT_W-1:0]    cosV;
        logic signed [LUT_W-1:0]    sinV;
        logic signed [OUT_W-1:0]    decI;
        logic signed [OUT_W-1:0]    decQ;
        logic                       decValid;
        wire [1:0]  pins   = d == 0 ? hopPinsA : hopPinsB;
        wire        active = d == 0 || dualMode_r;
        wire signed [SAMPLE_W-1:0] src =
            dualMode_r && inputBinding_r[d] ? sampleB : sampleA;
        wire signed [PROD_W-1:0] prodI = smp_r * cosV;
        wire signed [PROD_W-1:0] prodQ = smp_r * sinV;

        assign activeSel[d] = oscSelectSource_r ?
            hopPipe_r[HOP_DELAY-1] : oscSelectField_r[d];

        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst)
                hopPipe_r <= '0;
            else
                hopPipe_r <= {hopPipe_r[HOP_DELAY-2:0], pins};
        end

        dncm_nco u_nco (
            .sys_clk      (sys_clk),
            .rst          (rst),
            .freqWords    (freqWord_r[d]),
            .phaseOffsets (phaseOffset_r[d]),
            .rdiv         (rationalStepDivider_r),
            .oscSel       (activeSel[d]),
            .cosOut       (cosV),
            .sinOut       (sinV)
        );

        // complex mix, sample delayed to meet the carrier
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                smp_r      <= '0;
                mixI_r     <= '0;
                mixQ_r     <= '0;
                mixValid_r <= 1'b0;
            end else begin
                smp_r      <= src;
                mixI_r     <= rnd_sat(40'(prodI), MIX_SHIFT);
                mixQ_r     <= rnd_sat(40'(prodQ), MIX_SHIFT);
                mixValid_r <= active && !bypass_r;
            end
        end

        dncm_decim u_decim (
            .sys_clk  (sys_clk),
            .rst      (rst),
            .inI      (mixI_r),
            .inQ      (mixQ_r),
            .inValid  (mixValid_r),
            .outI     (decI),
            .outQ     (decQ),
            .outValid (decValid)
        );

        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                outI_r[d]     <= '0;
                outQ_r[d]     <= '0;
                outValid_r[d] <= 1'b0;
            end else if (!active) begin
                outI_r[d]     <= '0;
                outQ_r[d]     <= '0;
                outValid_r[d] <= 1'b0;
            end else if (bypass_r) begin
                outI_r[d]     <= OUT_W'(src);
                outQ_r[d]     <= '0;
                outValid_r[d] <= 1'b1;
            end else begin
                outI_r[d]     <= decI;
                outQ_r[d]     <= decQ;
                outValid_r[d] <= decValid;
            end
        end
    end

    assign outIA     = outI_r[0];
    assign outQA     = outQ_r[0];
    assign outValidA = outValid_r[0];
    assign outIB     = outI_r[1];
    assign outQB     = outQ_r[1];
    assign outValidB = outValid_r[1];

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    chk_bypass_path:
        assert property (bypass_r && !dualMode_r |=>
            outValidA && outIA == OUT_W'($past(sampleA)))
        else $error("bypass sample not passed through");
    chk_single_off:
        assert property (!dualMode_r |=> !outValidB && outIB == '0)
        else $error("second converter active in single mode");
    chk_bind_b:
        assert property (dualMode_r && bypass_r && inputBinding_r[1] |=>
            outIB == OUT_W'($past(sampleB)))
        else $error("input binding to channel B ignored");
    chk_hop_delay:
        assert property (oscSelectSource_r |->
            activeSel[0] == $past(hopPinsA, HOP_DELAY))
        else $error("hop pins not applied after the delay");
    chk_sel_field:
        assert property (!oscSelectSource_r && $stable(oscSelectField_r) |->
            activeSel[1] == oscSelectField_r[1])
        else $error("field does not choose the oscillator");
    chk_freq_write:
        assert property (apbWrite && paddr == 8'h34 && pstrb == 4'hf |=>
            freqWord_r[1][1] == $past(pwdata))
        else $error("frequency word write lost");
    chk_unmapped_err:
        assert property (psel && penable && paddr == 8'hfc |->
            pslverr && pready)
        else $error("unmapped access not flagged");
    chk_read_data:
        assert property (rdSetup && hitRdiv ##1 psel && penable |->
            prdata == {16'h0, $past(rationalStepDivider_r)})
        else $error("divider read back wrong");
    cov_hop: cover property (oscSelectSource_r && $changed(activeSel[0]));
    cov_bypass: cover property (bypass_r && outValidA);
    cov_dual_b: cover property (dualMode_r && outValidB && !bypass_r);
endmodule : dncm_top
`default_nettype wire

/* sim/dncm_adc_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dncm_adc_model import dncm_pkg::*; (
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    // levels to digitize
    input  wire logic signed [SAMPLE_W-1:0] levelA,
    input  wire logic signed [SAMPLE_W-1:0] levelB,
    // converter samples, one per clock
    output logic signed [SAMPLE_W-1:0]      sampleA,
    output logic signed [SAMPLE_W-1:0]      sampleB,
    // transmitter side
    input  wire logic                       outValidA,
    output int                              validCount
);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sampleA    <= '0;
            sampleB    <= '0;
            validCount <= 0;
        end else begin
            sampleA    <= levelA;
            sampleB    <= levelB;
            validCount <= validCount + int'(outValidA);
        end
    end
endmodule : dncm_adc_model
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench import dncm_pkg::*; ;
    logic                       sys_clk = 1'b0;
    logic                       rst = 1'b1;
    logic                       psel = 1'b0;
    logic                       penable = 1'b0;
    logic                       pwrite = 1'b0;
    logic [7:0]                 paddr = '0;
    logic [31:0]                pwdata = '0;
    logic [3:0]                 pstrb = 4'hf;
    logic [31:0]                prdata, rd;
    logic                       pready, pslverr, err;
    logic signed [SAMPLE_W-1:0] levelA = '0;
    logic signed [SAMPLE_W-1:0] levelB = '0;
    logic signed [SAMPLE_W-1:0] sampleA, sampleB;
    logic [1:0]                 hopPinsA = 2'h0;
    logic [1:0]                 hopPinsB = 2'h0;
    logic signed [OUT_W-1:0]    outIA, outQA, outIB, outQB;
    logic                       outValidA, outValidB;
    int                         validCount, snap;
    int                         failures = 0;
    int                         check_count = 0;

    always #5 sys_clk = ~sys_clk;

    dncm_adc_model i_dncm_adc_model (.sys_clk, .rst, .levelA, .levelB,
        .sampleA, .sampleB, .outValidA, .validCount);
    dncm_top i_dncm_top (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .sampleA, .sampleB,
        .hopPinsA, .hopPinsB, .outIA, .outQA, .outValidA, .outIB, .outQB,
        .outValidB);

    task automatic end_sim;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    task automatic timeout;
        failures++;
        $display("Error at %0t: wait timed out", $time);
        end_sim();
    endtask : timeout

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        @(posedge sys_clk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge sys_clk);
        end
        if (pready !== 1'b1)
            timeout();
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // let the pipeline flush, then stop on an output pulse
    task automatic wait_out;
        int n;
        repeat (24) @(posedge sys_clk);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (outValidA !== 1'b1 && n < 20);
        if (outValidA !== 1'b1)
            timeout();
    endtask : wait_out

    task automatic t_regs;
        apb(1'b0, ADDR_CTRL, '0);
        chk(rd, CTRL_RST);
        apb(1'b0, ADDR_RDIV, '0);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 8'hfc, '0);
        chk({31'h0, err}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        $display("test regs done");
    endtask : t_regs

    task automatic t_bypass;
        levelA <= -12'sd5;
        levelB <= 12'sh123;
        apb(1'b1, ADDR_CTRL, 32'h0000_0003);
        repeat (3) @(posedge sys_clk);
        chk(outIA, -5);
        chk(outValidA, 1);
        chk(outIB, -5);
        apb(1'b1, ADDR_CTRL, 32'h0000_001b);
        repeat (3) @(posedge sys_clk);
        chk(outIA, 32'h123);
        chk(outIB, 32'h123);
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        repeat (3) @(posedge sys_clk);
        chk(outValidB, 0);
        chk(outIB, 0);
        $display("test bypass done");
    endtask : t_bypass

    task automatic t_mix;
        levelA <= 12'sd512;
        apb(1'b1, ADDR_CTRL, CTRL_RST);
        wait_out();
        chk(outIA, 4096);
        chk(outQA, 0);
        chk(outIB, 4096);
        chk(outQB, 0);
        levelA <= -12'sd512;
        wait_out();
        chk(outIA, -4096);
        snap = validCount;
        repeat (40) @(posedge sys_clk);
        chk(validCount - snap, 10);
        $display("test mix done");
    endtask : t_mix

    task automatic t_freq;
        levelA <= 12'sd512;
        apb(1'b1, 8'h20, 32'h8000_0000);
        apb(1'b1, 8'h28, 32'h1234_5678);
        wait_out();
        chk(outIA, 0);
        chk(outQA, 0);
        $display("test freq done");
    endtask : t_freq

    task automatic t_phase;
        apb(1'b1, 8'h44, 32'h0000_4000);
        apb(1'b1, ADDR_CTRL, 32'h0000_0102);
        wait_out();
        chk(outIA, 0);
        chk(outQA, 4096);
        $display("test phase done");
    endtask : t_phase

    task automatic t_hop;
        apb(1'b1, ADDR_CTRL, 32'h0000_0006);
        hopPinsA <= 2'h1;
        repeat (40) @(posedge sys_clk);
        apb(1'b0, ADDR_STAT, '0);
        chk(rd[1:0], 0);
        repeat (20) @(posedge sys_clk);
        apb(1'b0, ADDR_STAT, '0);
        chk(rd[1:0], 1);
        wait_out();
        chk(outQA, 4096);
        $display("test hop done");
    endtask : t_hop

    task automatic t_rat;
        logic [31:0] word;
        word = 32'(((64'd1 << 27) * 502 + 1920) / 3840);
        apb(1'b1, ADDR_RDIV, 32'd1920);
        apb(1'b0, ADDR_STAT, '0);
        chk(rd[4], 1);
        apb(1'b1, 8'h24, word);
        apb(1'b0, 8'h24, '0);
        chk(rd, word);
        apb(1'b1, 8'h34, word);
        apb(1'b0, 8'h34, '0);
        chk(rd, word);
        apb(1'b0, ADDR_RDIV, '0);
        chk(rd, 32'd1920);
        apb(1'b1, ADDR_RDIV, 32'd1);
        repeat (70) @(posedge sys_clk);
        apb(1'b1, ADDR_RDIV, '0);
        apb(1'b0, ADDR_STAT, '0);
        chk(rd[4], 0);
        $display("test rational done");
    endtask : t_rat

    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_bypass();
        t_mix();
        t_freq();
        t_phase();
        t_hop();
        t_rat();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
